// file: aux_relay_regs.vh
`ifndef AUX_RELAY_REGS_VH
`define AUX_RELAY_REGS_VH

// register byte offsets
`define OFS_STATUS        8'h00
`define OFS_TRIP9         8'h04
`define OFS_TRIP10        8'h08
`define OFS_TRIP11        8'h0C
`define OFS_BAND9         8'h10
`define OFS_BAND10        8'h14
`define OFS_BAND11        8'h18

// status word fields
`define ST_ENERGIZED_LO   0
`define ST_CHANGED_LO     4
`define ST_SENSOR_BIT     8
`define ST_SYS_LO         12
`define ST_VOLTS_LO       16

// battery system selection
`define SYS_12V           2'h0
`define SYS_24V           2'h1
`define SYS_48V           2'h2

// trip ranges, 0.1 V units
`define TRIP_MIN_12       10'h032
`define TRIP_MAX_12       10'h0B0
`define TRIP_MIN_24       10'h064
`define TRIP_MAX_24       10'h163
`define TRIP_MIN_48       10'h0C8
`define TRIP_MAX_48       10'h2C6

// release band range, raw steps (0.1 V, or 0.2 V on 48 V)
`define BAND_MIN          8'h01
`define BAND_MAX          8'h80

// trip defaults, 0.1 V units
`define TRIP9_DEF_12      10'h091
`define TRIP9_DEF_24      10'h122
`define TRIP9_DEF_48      10'h244
`define TRIP10_DEF_12     10'h094
`define TRIP10_DEF_24     10'h127
`define TRIP10_DEF_48     10'h24E
`define TRIP11_DEF_12     10'h096
`define TRIP11_DEF_24     10'h12C
`define TRIP11_DEF_48     10'h258

// release band defaults, raw steps
`define BAND_DEF_12       8'h0A
`define BAND_DEF_24       8'h14
`define BAND_DEF_48       8'h14

// delays
`define CLK_FREQ_KHZ      200000
`define CLOSE_DELAY_MS    2000
`define OPEN_DELAY_MS     100

`endif

// file: volt_comp.v
`timescale 1ns/1ps
module volt_comp (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // measurement
    input  wire [9:0]  batt_volts_i,
    input  wire        sensor_present_i,
    input  wire [7:0]  temp_offset_i,
    // result
    output wire [9:0]  comp_volts_o
);

    reg  [9:0]  comp_q;
    reg  [9:0]  comp_d;
    wire [11:0] sum;

    // offset is two's complement, 0.1 V units
    assign sum = {2'h0, batt_volts_i} + {{4{temp_offset_i[7]}}, temp_offset_i};

    always @* begin
        comp_d = batt_volts_i;
        if (sensor_present_i) begin
            if (sum[11])
                comp_d = 10'h000;
            else if (sum[10])
                comp_d = 10'h3FF;
            else
                comp_d = sum[9:0];
        end
    end

    always @(posedge clk_i) begin
        if (rst_i)
            comp_q <= 10'h000;
        else
            comp_q <= comp_d;
    end

    assign comp_volts_o = comp_q;

endmodule

// file: relay_channel.v
`timescale 1ns/1ps
`include "aux_relay_regs.vh"
module relay_channel #(
    parameter integer CLOSE_CYCLES = `CLOSE_DELAY_MS * `CLK_FREQ_KHZ,
    parameter integer OPEN_CYCLES  = `OPEN_DELAY_MS * `CLK_FREQ_KHZ
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // comparison inputs, 0.1 V units
    input  wire [9:0]  volts_i,
    input  wire [9:0]  trip_i,
    input  wire [9:0]  band_i,
    // relay state
    output wire        energized_o
);

    localparam [31:0] CLOSE_LIM = CLOSE_CYCLES - 1;
    localparam [31:0] OPEN_LIM  = OPEN_CYCLES - 1;

    reg         on_q;
    reg         on_d;
    reg  [31:0] cnt_q;
    reg  [31:0] cnt_d;
    wire        above;
    wire        below;
    wire        go;
    wire [31:0] lim;

    assign above = volts_i > trip_i;
    // widened so volts plus band cannot wrap past 10 bits
    assign below = ({1'b0, volts_i} + {1'b0, band_i}) < {1'b0, trip_i};
    assign go    = on_q ? below : above;
    assign lim   = on_q ? OPEN_LIM : CLOSE_LIM;

    always @* begin
        on_d  = on_q;
        cnt_d = 32'h0000_0000;
        if (go) begin
            if (cnt_q >= lim)
                on_d = ~on_q;
            else
                cnt_d = cnt_q + 32'h0000_0001;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            on_q  <= 1'b0;
            cnt_q <= 32'h0000_0000;
        end else begin
            on_q  <= on_d;
            cnt_q <= cnt_d;
        end
    end

    assign energized_o = on_q;

endmodule

// file: aux_relay_ctrl.v
`timescale 1ns/1ps
`include "aux_relay_regs.vh"
module aux_relay_ctrl #(
    parameter [1:0]   SYS_SEL      = `SYS_12V,
    parameter integer CLOSE_CYCLES = `CLOSE_DELAY_MS * `CLK_FREQ_KHZ,
    parameter integer OPEN_CYCLES  = `OPEN_DELAY_MS * `CLK_FREQ_KHZ
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output wire [31:0] dat_o,
    output wire        ack_o,
    // battery measurement
    input  wire [9:0]  batt_volts_i,
    input  wire        battery_temp_sensor_i,
    input  wire [7:0]  temp_offset_i,
    // relay coil drives, bit 0 is channel 9
    output wire [2:0]  relay_coil_o
);

    localparam [9:0] TRIP_MIN =
        (SYS_SEL == `SYS_48V) ? `TRIP_MIN_48 :
        (SYS_SEL == `SYS_24V) ? `TRIP_MIN_24 : `TRIP_MIN_12;
    localparam [9:0] TRIP_MAX =
        (SYS_SEL == `SYS_48V) ? `TRIP_MAX_48 :
        (SYS_SEL == `SYS_24V) ? `TRIP_MAX_24 : `TRIP_MAX_12;
    localparam [9:0] TRIP9_DEF =
        (SYS_SEL == `SYS_48V) ? `TRIP9_DEF_48 :
        (SYS_SEL == `SYS_24V) ? `TRIP9_DEF_24 : `TRIP9_DEF_12;
    localparam [9:0] TRIP10_DEF =
        (SYS_SEL == `SYS_48V) ? `TRIP10_DEF_48 :
        (SYS_SEL == `SYS_24V) ? `TRIP10_DEF_24 : `TRIP10_DEF_12;
    localparam [9:0] TRIP11_DEF =
        (SYS_SEL == `SYS_48V) ? `TRIP11_DEF_48 :
        (SYS_SEL == `SYS_24V) ? `TRIP11_DEF_24 : `TRIP11_DEF_12;
    localparam [7:0] BAND_DEF =
        (SYS_SEL == `SYS_48V) ? `BAND_DEF_48 :
        (SYS_SEL == `SYS_24V) ? `BAND_DEF_24 : `BAND_DEF_12;
    localparam       BAND_X2 = (SYS_SEL == `SYS_48V);

    // bus handshake
    reg         ack_q;
    reg  [31:0] dat_q;
    reg  [31:0] rd_d;
    wire        req;
    wire        wr;

    // settings
    reg  [9:0]  trip9_q;
    reg  [9:0]  trip10_q;
    reg  [9:0]  trip11_q;
    reg  [7:0]  band9_q;
    reg  [7:0]  band10_q;
    reg  [7:0]  band11_q;
    reg  [9:0]  trip_new;
    reg  [7:0]  band_new;
    reg         trip_ok;
    reg         band_ok;

    // status
    reg  [2:0]  changed_q;
    reg  [2:0]  changed_d;
    reg  [2:0]  coil_prev_q;
    wire [2:0]  coil;
    wire [9:0]  comp_volts;
    wire [9:0]  band9_eff;
    wire [9:0]  band10_eff;
    wire [9:0]  band11_eff;

    assign req = cyc_i & stb_i & ~ack_q;
    assign wr  = req & we_i;

    // byte-lane merge of a write onto the addressed setting
    always @* begin
        trip_new = trip9_q;
        band_new = band9_q;
        if (adr_i == `OFS_TRIP10)
            trip_new = trip10_q;
        else if (adr_i == `OFS_TRIP11)
            trip_new = trip11_q;
        if (adr_i == `OFS_BAND10)
            band_new = band10_q;
        else if (adr_i == `OFS_BAND11)
            band_new = band11_q;
        if (sel_i[0]) begin
            trip_new[7:0] = dat_i[7:0];
            band_new      = dat_i[7:0];
        end
        if (sel_i[1])
            trip_new[9:8] = dat_i[9:8];
        // out-of-range writes are dropped, keeping the last legal value
        trip_ok = (trip_new >= TRIP_MIN) && (trip_new <= TRIP_MAX);
        band_ok = (band_new >= `BAND_MIN) && (band_new <= `BAND_MAX);
    end

    // settings registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            trip9_q  <= TRIP9_DEF;
            trip10_q <= TRIP10_DEF;
            trip11_q <= TRIP11_DEF;
            band9_q  <= BAND_DEF;
            band10_q <= BAND_DEF;
            band11_q <= BAND_DEF;
        end else if (wr) begin
            if (adr_i == `OFS_TRIP9) begin
                if (trip_ok)
                    trip9_q <= trip_new;
            end else if (adr_i == `OFS_TRIP10) begin
                if (trip_ok)
                    trip10_q <= trip_new;
            end else if (adr_i == `OFS_TRIP11) begin
                if (trip_ok)
                    trip11_q <= trip_new;
            end else if (adr_i == `OFS_BAND9) begin
                if (band_ok)
                    band9_q <= band_new;
            end else if (adr_i == `OFS_BAND10) begin
                if (band_ok)
                    band10_q <= band_new;
            end else if (adr_i == `OFS_BAND11) begin
                if (band_ok)
                    band11_q <= band_new;
            end
        end
    end

    // read mux, unmapped offsets read as zero
    always @* begin
        rd_d = 32'h0000_0000;
        if (adr_i == `OFS_STATUS) begin
            rd_d[`ST_ENERGIZED_LO +: 3] = coil;
            rd_d[`ST_CHANGED_LO +: 3]   = changed_q;
            rd_d[`ST_SENSOR_BIT]        = battery_temp_sensor_i;
            rd_d[`ST_SYS_LO +: 2]       = SYS_SEL;
            rd_d[`ST_VOLTS_LO +: 10]    = comp_volts;
        end else if (adr_i == `OFS_TRIP9) begin
            rd_d[9:0] = trip9_q;
        end else if (adr_i == `OFS_TRIP10) begin
            rd_d[9:0] = trip10_q;
        end else if (adr_i == `OFS_TRIP11) begin
            rd_d[9:0] = trip11_q;
        end else if (adr_i == `OFS_BAND9) begin
            rd_d[7:0] = band9_q;
        end else if (adr_i == `OFS_BAND10) begin
            rd_d[7:0] = band10_q;
        end else if (adr_i == `OFS_BAND11) begin
            rd_d[7:0] = band11_q;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req)
                dat_q <= rd_d;
        end
    end

    // sticky change flags, write one to clear; a new change wins over the clear
    always @* begin
        changed_d = changed_q;
        if (wr && adr_i == `OFS_STATUS && sel_i[0])
            changed_d = changed_q & ~dat_i[`ST_CHANGED_LO +: 3];
        changed_d = changed_d | (coil ^ coil_prev_q);
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            changed_q   <= 3'h0;
            coil_prev_q <= 3'h0;
        end else begin
            changed_q   <= changed_d;
            coil_prev_q <= coil;
        end
    end

    // compensated voltage shared by all channels
    volt_comp u_comp (
        .clk_i            (clk_i),
        .rst_i            (rst_i),
        .batt_volts_i     (batt_volts_i),
        .sensor_present_i (battery_temp_sensor_i),
        .temp_offset_i    (temp_offset_i),
        .comp_volts_o     (comp_volts)
    );

    // 48 V bands count 0.2 V steps, so double them into 0.1 V counts
    assign band9_eff  = BAND_X2 ? {1'b0, band9_q, 1'b0}  : {2'h0, band9_q};
    assign band10_eff = BAND_X2 ? {1'b0, band10_q, 1'b0} : {2'h0, band10_q};
    assign band11_eff = BAND_X2 ? {1'b0, band11_q, 1'b0} : {2'h0, band11_q};

    // no inverter-on input exists, so nothing can halt a channel
    relay_channel #(
        .CLOSE_CYCLES (CLOSE_CYCLES),
        .OPEN_CYCLES  (OPEN_CYCLES)
    ) u_ch9 (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .volts_i     (comp_volts),
        .trip_i      (trip9_q),
        .band_i      (band9_eff),
        .energized_o (coil[0])
    );

    relay_channel #(
        .CLOSE_CYCLES (CLOSE_CYCLES),
        .OPEN_CYCLES  (OPEN_CYCLES)
    ) u_ch10 (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .volts_i     (comp_volts),
        .trip_i      (trip10_q),
        .band_i      (band10_eff),
        .energized_o (coil[1])
    );

    relay_channel #(
        .CLOSE_CYCLES (CLOSE_CYCLES),
        .OPEN_CYCLES  (OPEN_CYCLES)
    ) u_ch11 (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .volts_i     (comp_volts),
        .trip_i      (trip11_q),
        .band_i      (band11_eff),
        .energized_o (coil[2])
    );

    // coil high ties the open contact to common, low the closed one
    assign relay_coil_o = coil;
    assign ack_o        = ack_q;
    assign dat_o        = dat_q;

endmodule

// file: batt_meter.sv
`timescale 1ns/1ps
module batt_meter (
    // clock
    input  wire logic       clk_i,
    // wanted reading
    input  wire logic [9:0] level_i,
    input  wire logic       sensor_i,
    input  wire logic [7:0] offset_i,
    // measured values
    output logic      [9:0] volts_o,
    output logic            sensor_o,
    output logic      [7:0] offset_o
);
    initial begin
        volts_o = 10'h000;
        sensor_o = 1'b0;
        offset_o = 8'h00;
    end
    // one cycle of conversion latency, so the bench never lines up with the dut by luck
    always @(posedge clk_i) begin
        volts_o <= level_i;
        sensor_o <= sensor_i;
        offset_o <= offset_i;
    end
endmodule

// file: aux_relay_chk.sv
`timescale 1ns/1ps
`include "aux_relay_regs.vh"
module aux_relay_chk #(
    parameter [1:0]   SYS_SEL      = `SYS_12V,
    parameter integer CLOSE_CYCLES = 20,
    parameter integer OPEN_CYCLES  = 4
) (
    // clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // wishbone slave
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    // measurement and coils
    input wire [9:0]  batt_volts_i,
    input wire        battery_temp_sensor_i,
    input wire [7:0]  temp_offset_i,
    input wire [2:0]  relay_coil_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // run lengths of the channel 9 coil, saturated at the delay they guard
    int unsigned low_run;
    int unsigned high_run;
    always @(posedge clk_i) begin
        if (rst_i || relay_coil_o[0])
            low_run <= 0;
        else if (low_run < CLOSE_CYCLES)
            low_run <= low_run + 1;
        if (rst_i || !relay_coil_o[0])
            high_run <= 0;
        else if (high_run < OPEN_CYCLES)
            high_run <= high_run + 1;
    end
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_on4;
        relay_coil_o[0] [*4];
    endsequence
    sequence s_off8;
        !relay_coil_o[0] [*8];
    endsequence
    a_ack_follows_req: assert property (s_req |=> ack_o)
        else $error("no ack after request");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_no_stray_ack: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_reset_clears: assert property (disable iff (1'b0)
        rst_i |=> relay_coil_o == 3'h0 && !ack_o && dat_o == 32'h0)
        else $error("outputs not cleared by reset");
    a_unmapped_zero: assert property (ack_o && $past(!we_i && adr_i > 8'h1B) |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_trip_upper_zero: assert property (
        ack_o && $past(!we_i && adr_i inside {`OFS_TRIP9, `OFS_TRIP10, `OFS_TRIP11})
        |-> dat_o[31:10] == 22'h0)
        else $error("trip read upper bits set");
    a_band_upper_zero: assert property (
        ack_o && $past(!we_i && adr_i inside {`OFS_BAND9, `OFS_BAND10, `OFS_BAND11})
        |-> dat_o[31:8] == 24'h0)
        else $error("band read upper bits set");
    a_status_sys: assert property (ack_o && $past(!we_i && adr_i == `OFS_STATUS)
        |-> dat_o[13:12] == SYS_SEL)
        else $error("status system field wrong");
    a_on_min_time: assert property ($rose(relay_coil_o[0]) |-> s_on4)
        else $error("coil released too soon");
    a_off_min_time: assert property ($fell(relay_coil_o[0]) |-> s_off8)
        else $error("coil closed too soon");
    a_close_wait_full: assert property ($rose(relay_coil_o[0]) |-> low_run >= CLOSE_CYCLES)
        else $error("coil closed before full close delay");
    a_open_wait_full: assert property ($fell(relay_coil_o[0]) |-> high_run >= OPEN_CYCLES)
        else $error("coil opened before full open delay");
endmodule
bind aux_relay_ctrl aux_relay_chk #(
    .SYS_SEL(SYS_SEL), .CLOSE_CYCLES(CLOSE_CYCLES), .OPEN_CYCLES(OPEN_CYCLES)
) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .batt_volts_i(batt_volts_i), .battery_temp_sensor_i(battery_temp_sensor_i),
    .temp_offset_i(temp_offset_i), .relay_coil_o(relay_coil_o)
);

// file: test_battery_voltage_aux_relay_ctrl.sv
`timescale 1ns/1ps
`include "aux_relay_regs.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module test_battery_voltage_aux_relay_ctrl;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, sens_q, ack_o, sensor_w;
    logic [7:0]  adr_i, ofs_q, offset_w;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, rdata;
    logic [9:0]  level_q, volts_w;
    logic [2:0]  relay_coil_o, coil48_o;
    logic [31:0] dat48_o, rdata48;
    logic        ack48_o;
    int          n_fail, checks_done, n_cyc;
    batt_meter meter_u (.clk_i(clk_i), .level_i(level_q), .sensor_i(sens_q), .offset_i(ofs_q),
        .volts_o(volts_w), .sensor_o(sensor_w), .offset_o(offset_w));
    aux_relay_ctrl #(.SYS_SEL(`SYS_12V), .CLOSE_CYCLES(20), .OPEN_CYCLES(4)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .batt_volts_i(volts_w), .battery_temp_sensor_i(sensor_w),
        .temp_offset_i(offset_w), .relay_coil_o(relay_coil_o));
    // same bus and meter, 48 V system: checks the other defaults and ranges
    aux_relay_ctrl #(.SYS_SEL(`SYS_48V), .CLOSE_CYCLES(20), .OPEN_CYCLES(4)) dut48_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat48_o), .ack_o(ack48_o),
        .batt_volts_i(volts_w), .battery_temp_sensor_i(sensor_w),
        .temp_offset_i(offset_w), .relay_coil_o(coil48_o));
    task automatic report_and_stop;
        if (n_fail == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // the bench timeout bounds the wait for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rdata = dat_o;
        rdata48 = dat48_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(rdata, e)
    endtask
    task automatic drive(input logic [9:0] v, input int n);
        level_q <= v;
        step(n);
    endtask
    task automatic t_defaults;
        rd(`OFS_STATUS, 32'h0);
        `CHK(rdata48, 32'h0000_2000)
        rd(`OFS_TRIP9, 32'h91);
        `CHK(rdata48, 32'h244)
        rd(`OFS_TRIP10, 32'h94);
        `CHK(rdata48, 32'h24E)
        rd(`OFS_TRIP11, 32'h96);
        `CHK(rdata48, 32'h258)
        rd(`OFS_BAND9, 32'h0A);
        `CHK(rdata48, 32'h14)
        rd(`OFS_BAND10, 32'h0A);
        `CHK(rdata48, 32'h14)
        rd(`OFS_BAND11, 32'h0A);
        `CHK(rdata48, 32'h14)
        wb(1'b1, 8'h40, 32'hFFFF);
        rd(8'h40, 32'h0);
    endtask
    task automatic t_ranges;
        wb(1'b1, `OFS_TRIP9, 32'h31);
        rd(`OFS_TRIP9, 32'h91);
        wb(1'b1, `OFS_TRIP9, 32'h32);
        rd(`OFS_TRIP9, 32'h32);
        `CHK(rdata48, 32'h244)
        wb(1'b1, `OFS_TRIP9, 32'hB1);
        rd(`OFS_TRIP9, 32'h32);
        wb(1'b1, `OFS_TRIP9, 32'hB0);
        rd(`OFS_TRIP9, 32'hB0);
        wb(1'b1, `OFS_TRIP9, 32'h91);
        wb(1'b1, `OFS_BAND9, 32'h00);
        rd(`OFS_BAND9, 32'h0A);
        wb(1'b1, `OFS_BAND9, 32'h81);
        rd(`OFS_BAND9, 32'h0A);
        wb(1'b1, `OFS_BAND9, 32'h80);
        rd(`OFS_BAND9, 32'h80);
        `CHK(rdata48, 32'h80)
        wb(1'b1, `OFS_BAND9, 32'h0A);
    endtask
    task automatic t_relay;
        drive(10'd146, 10);
        drive(10'd145, 3);
        drive(10'd146, 18);
        `CHK(relay_coil_o, 3'b000)
        step(8);
        `CHK(relay_coil_o, 3'b001)
        drive(10'd136, 12);
        `CHK(relay_coil_o, 3'b001)
        drive(10'd134, 2);
        `CHK(relay_coil_o, 3'b001)
        step(6);
        `CHK(relay_coil_o, 3'b000)
        drive(10'd145, 30);
        `CHK(relay_coil_o, 3'b000)
        drive(10'd160, 26);
        `CHK(relay_coil_o, 3'b111)
        `CHK(coil48_o, 3'b000)
        wb(1'b0, `OFS_STATUS, 32'h0);
        `CHK(rdata[2:0], 3'b111)
        `CHK(rdata, 32'h00A0_0077)
        wb(1'b1, `OFS_STATUS, 32'h70);
        rd(`OFS_STATUS, 32'h00A0_0007);
        drive(10'd139, 10);
        `CHK(relay_coil_o, 3'b011)
        drive(10'd100, 10);
        `CHK(relay_coil_o, 3'b000)
    endtask
    task automatic t_comp;
        sens_q <= 1'b1;
        ofs_q <= 8'h05;
        drive(10'd141, 26);
        `CHK(relay_coil_o, 3'b001)
        rd(`OFS_STATUS, 32'h0092_0171);
        ofs_q <= 8'hF6;
        step(10);
        `CHK(relay_coil_o, 3'b000)
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        n_cyc++;
        if (n_cyc == 3000) begin
            n_fail++;
            $display("[ERR] %0t timeout", $time);
            report_and_stop;
        end
    end
    initial begin
        {rst_i, cyc_i, stb_i, we_i, sens_q} = 5'b10000;
        {adr_i, ofs_q, dat_i, level_q} = '0;
        sel_i = 4'hF;
        step(5);
        rst_i <= 1'b0;
        t_defaults;
        t_ranges;
        t_relay;
        t_comp;
        report_and_stop;
    end
endmodule
